// >>> core/smc_defs.vh
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
// register byte offsets
`define SMC_ADDR_CLK 8'h00
`define SMC_ADDR_CTL 8'h04
`define SMC_ADDR_FLAG 8'h08
`define SMC_ADDR_IE 8'h0c
// clock config fields and reset value
`define SMC_CLK_DEBUG_CLOCK_RUN 8
`define SMC_CLK_DIV_HI 6
`define SMC_CLK_DIV_LO 4
`define SMC_CLK_SRC_HI 1
`define SMC_CLK_SRC_LO 0
`define SMC_CLK_DEBUG_CLOCK_RUN_RST 1'b1
`define SMC_CLK_DIV_RST 3'h0
`define SMC_CLK_SRC_RST 2'h0
// control fields
`define SMC_CTL_SRCSEL 15
`define SMC_CTL_SC_HI 14
`define SMC_CTL_SC_LO 13
`define SMC_CTL_THR_HI 12
`define SMC_CTL_THR_LO 8
`define SMC_CTL_RE_HI 7
`define SMC_CTL_RE_LO 4
`define SMC_CTL_MD_HI 2
`define SMC_CTL_MD_LO 1
`define SMC_CTL_EN 0
// flag and irq-enable register fields
`define SMC_FLAG_STAT 8
`define SMC_FLAG_LV 0
`define SMC_IE_BIT 0
// codes
`define SMC_RESET_SEL_CODE 4'ha
`define SMC_THR_MIN 5'h01
`define SMC_THR_MAX 5'h1e
`define SMC_SRC_RC 2'h0
`define SMC_SRC_LSO 2'h1
`define SMC_SRC_HSO 2'h2
`define SMC_SRC_EXT 2'h3
`define SMC_DIV_MAX 3'h5
// intermittent periods minus one, in detector clock ticks
`define SMC_PER_128 10'h07f
`define SMC_PER_256 10'h0ff
`define SMC_PER_512 10'h1ff
// timing
`define SMC_CLK_PERIOD_NS 8
`define SMC_DISABLE_NS 64
// axi responses
`define SMC_RESP_OKAY 2'h0
`define SMC_RESP_SLVERR 2'h2
`endif

// >>> core/smc_det_clk_gen.v
`include "smc_defs.vh"

module smc_det_clk_gen #(
	parameter CNT_W = 7
) (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire [3:0] src_tick, // one-cycle ticks of rc, lso, hso, ext sources
	input wire [1:0] src_sel, // clock source field
	input wire [2:0] div_sel, // clock divider field
	input wire run, // clock allowed to run
	output reg tick_q // one-cycle detector clock enable
);

reg [CNT_W-1:0] cnt_q;
reg [CNT_W-1:0] lim;
wire pick = src_tick[src_sel]; // [R14]
wire divided = (src_sel == `SMC_SRC_RC) || (src_sel == `SMC_SRC_HSO);
// reserved divider codes on divided sources give no clock at all
wire reserved = divided && (div_sel > `SMC_DIV_MAX);

always @* begin
	case (div_sel)
		3'h0: lim = 7'h03; // [R15]
		3'h1: lim = 7'h07;
		3'h2: lim = 7'h0f;
		3'h3: lim = 7'h1f;
		3'h4: lim = 7'h3f;
		default: lim = 7'h7f;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn || !run) begin
		cnt_q <= {CNT_W{1'b0}};
		tick_q <= 1'b0;
	end else begin
		tick_q <= 1'b0;
		if (pick) begin
			if (!divided) begin
				tick_q <= 1'b1; // [R15]
			end else if (!reserved) begin
				if (cnt_q == lim) begin
					cnt_q <= {CNT_W{1'b0}};
					tick_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
end

endmodule

// >>> core/smc_supply_monitor.v
// Notes on behaviour
// [R1] reset-select not 0xa: events set flag only
// [R2] continuous: flag on low; intermittent: after count
// [R3] flag sticky, cleared only by writing 1
// [R4] irq while flag set and enable 1; the code also holds irq low while reset-select is 0xa
// [R5] reset-select 0xa: detection issues system reset
// [R6] reset asserted when flag would be set
// [R7] after reset, run continuous and keep monitoring
// [R8] reset keeps external sense pin routed when selected
// [R9] reset released when status returns to 0
// [R10] reset restores debug-run, divider, source fields
// [R11] reset keeps source, threshold, select, enable, flag
// [R12] reset clears count, cycle select, irq enable
// [R13] debug-run bit keeps clock running in debug
// [R14] two-bit field selects one of four sources
// [R15] rc/hso divide 4..128; lso/ext undivided
// [R16] unimplemented sources cannot be selected
// [R17] intermittent needs 1,2,4,8 successive low detections
// [R18] count write only when cycle select nonzero
// [R19] threshold codes 0x01..0x1e only; others forbidden
// [R20] cycle select: continuous, or 128/256/512 periods
// [R21] control bit 15 selects monitored supply
// [R22] software unlocks protection around protected writes
// [R23] status reads 1 when below threshold
// [R24] disabling resets hardware; enable reads 0 after
// [R25] changing count/select/cycle fields reinitialises circuit
// [R26] a high detection restarts the low run
// [R27] reserved bits read 0, ignore writes
`include "smc_defs.vh"

module smc_supply_monitor #(
	parameter ADDR_W = 8,
	parameter [3:0] SRC_IMPL = 4'hf
) (
	input wire aclk, // 125 MHz system clock
	input wire aresetn, // synchronous reset, active low
	input wire [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write byte strobes
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [ADDR_W-1:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire [3:0] src_tick, // ticks of rc, lso, hso, ext clock sources
	input wire debug_mode, // cpu in debug mode
	input wire below_threshold_in, // comparator: supply below threshold
	output reg low_voltage_irq, // interrupt request
	output reg system_reset_req, // detector-issued system reset
	output reg comparator_enable, // analog comparator on
	output reg [4:0] threshold_level, // threshold to comparator
	output reg monitored_source_select, // 1 external sense pin, 0 core supply
	output reg external_sense_keep // keep sense pin routed during reset
);

localparam DIS_CYC = (`SMC_DISABLE_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS;
localparam [3:0] DIS_LIM = DIS_CYC[3:0] - 4'h1;
localparam [3:0] ST_OFF = 4'b0001;
localparam [3:0] ST_RUN = 4'b0010;
localparam [3:0] ST_DIS = 4'b0100;
localparam [3:0] ST_SRST = 4'b1000;

////////////////////////////////////////////////////////////////////////
// register state
reg debug_clock_run_q;
reg [2:0] clock_divider_q;
reg [1:0] clock_source_q;
reg [1:0] consec_count_q;
reg [3:0] reset_select_q;
reg [1:0] cycle_select_q;
reg low_voltage_flag_q;
reg below_threshold_status_q;
reg irq_enable_q;
reg [3:0] st_q;
reg [3:0] dis_cnt_q;
reg [9:0] per_cnt_q;
reg [2:0] run_cnt_q;
reg [ADDR_W-1:0] wr_addr_q;
reg [15:0] wr_data_q;
reg [1:0] wr_strb_q;

wire det_tick;
wire enabled = (st_q != ST_OFF);
wire clk_run = enabled && (st_q != ST_DIS) && (debug_clock_run_q || !debug_mode); // [R13]

smc_det_clk_gen #(
	.CNT_W(7)
) u_clk_gen (
	.aclk(aclk),
	.aresetn(aresetn),
	.src_tick(src_tick),
	.src_sel(clock_source_q),
	.div_sel(clock_divider_q),
	.run(clk_run),
	.tick_q(det_tick)
);

////////////////////////////////////////////////////////////////////////
// register views, reserved bits zero
function [15:0] reg_view;
	input [ADDR_W-1:0] a;
	begin
		case (a)
			`SMC_ADDR_CLK: reg_view = {7'h00, debug_clock_run_q, 1'b0, clock_divider_q, 2'h0, clock_source_q};
			`SMC_ADDR_CTL: reg_view = {monitored_source_select, consec_count_q, threshold_level,
				reset_select_q, 1'b0, cycle_select_q, enabled}; // [R24]
			`SMC_ADDR_FLAG: reg_view = {7'h00, below_threshold_status_q, 7'h00, low_voltage_flag_q};
			`SMC_ADDR_IE: reg_view = {15'h0000, irq_enable_q};
			default: reg_view = 16'h0000; // [R27]
		endcase
	end
endfunction

function mapped;
	input [ADDR_W-1:0] a;
	begin
		mapped = (a == `SMC_ADDR_CLK) || (a == `SMC_ADDR_CTL) || (a == `SMC_ADDR_FLAG) || (a == `SMC_ADDR_IE);
	end
endfunction

////////////////////////////////////////////////////////////////////////
// axi4-lite write path: address and data taken in either order
wire aw_fire = s_axi_awvalid && s_axi_awready;
wire w_fire = s_axi_wvalid && s_axi_wready;
wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
wire [15:0] wr_old = reg_view(wr_addr_q);
wire [15:0] wd = {wr_strb_q[1] ? wr_data_q[15:8] : wr_old[15:8], wr_strb_q[0] ? wr_data_q[7:0] : wr_old[7:0]};
// register writes are refused while the detector holds the system in reset
wire wr_ok = wr_go && (st_q != ST_SRST);
wire wr_clk = wr_ok && (wr_addr_q == `SMC_ADDR_CLK);
wire wr_ctl = wr_ok && (wr_addr_q == `SMC_ADDR_CTL);
wire wr_flag = wr_ok && (wr_addr_q == `SMC_ADDR_FLAG);
wire wr_ie = wr_ok && (wr_addr_q == `SMC_ADDR_IE);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `SMC_RESP_OKAY;
		wr_addr_q <= {ADDR_W{1'b0}};
		wr_data_q <= 16'h0000;
		wr_strb_q <= 2'h0;
	end else begin
		if (aw_fire) begin
			s_axi_awready <= 1'b0;
			wr_addr_q <= s_axi_awaddr;
		end
		if (w_fire) begin
			s_axi_wready <= 1'b0;
			wr_data_q <= s_axi_wdata[15:0];
			wr_strb_q <= s_axi_wstrb[1:0];
		end
		if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(wr_addr_q) ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// axi4-lite read path
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `SMC_RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= {16'h0000, reg_view(s_axi_araddr)}; // [R27]
		s_axi_rresp <= mapped(s_axi_araddr) ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
		s_axi_arready <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////
// detection
wire continuous = (cycle_select_q == 2'h0);
reg [9:0] per_lim;
reg [2:0] need_m1;

always @* begin
	case (cycle_select_q)
		2'h1: per_lim = `SMC_PER_128; // [R20]
		2'h2: per_lim = `SMC_PER_256;
		default: per_lim = `SMC_PER_512;
	endcase
	case (consec_count_q)
		2'h0: need_m1 = 3'h0; // [R17]
		2'h1: need_m1 = 3'h1;
		2'h2: need_m1 = 3'h3;
		default: need_m1 = 3'h7;
	endcase
end

wire sample = det_tick && (st_q == ST_RUN) && (continuous || (per_cnt_q == per_lim));
wire event_hit = sample && below_threshold_in && (continuous || (run_cnt_q == need_m1)); // [R2] [R17]
wire reset_mode = (reset_select_q == `SMC_RESET_SEL_CODE);
wire [15:0] ctl_new = wd;
wire md_new_nz = (ctl_new[`SMC_CTL_MD_HI:`SMC_CTL_MD_LO] != 2'h0);
wire [1:0] sc_new = md_new_nz ? ctl_new[`SMC_CTL_SC_HI:`SMC_CTL_SC_LO] : consec_count_q; // [R18]
wire [4:0] thr_new = ctl_new[`SMC_CTL_THR_HI:`SMC_CTL_THR_LO];
wire thr_ok = (thr_new >= `SMC_THR_MIN) && (thr_new <= `SMC_THR_MAX); // [R19]
wire flag_clr = wr_flag && wd[`SMC_FLAG_LV];
// reprogramming mode fields or clearing the flag mid-run restarts the sampling circuit
wire reinit = (st_q == ST_RUN) && ((wr_ctl && ((sc_new != consec_count_q) ||
	(ctl_new[`SMC_CTL_RE_HI:`SMC_CTL_RE_LO] != reset_select_q) ||
	(ctl_new[`SMC_CTL_MD_HI:`SMC_CTL_MD_LO] != cycle_select_q))) || flag_clr); // [R25]
wire enter_srst = event_hit && reset_mode; // [R5] [R6]

always @(posedge aclk) begin
	if (!aresetn || st_q != ST_RUN || reinit) begin
		per_cnt_q <= 10'h000;
		run_cnt_q <= 3'h0;
	end else if (det_tick && !continuous) begin
		if (per_cnt_q == per_lim) begin
			per_cnt_q <= 10'h000;
			if (!below_threshold_in || run_cnt_q == need_m1) begin
				run_cnt_q <= 3'h0; // [R26]
			end else begin
				run_cnt_q <= run_cnt_q + 3'h1;
			end
		end else begin
			per_cnt_q <= per_cnt_q + 10'h001;
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn || st_q == ST_OFF) begin
		below_threshold_status_q <= 1'b0;
	end else if (sample || (det_tick && st_q == ST_SRST)) begin
		below_threshold_status_q <= below_threshold_in; // [R23]
	end
end

////////////////////////////////////////////////////////////////////////
// enable state machine and detector-issued reset
always @(posedge aclk) begin
	if (!aresetn) begin
		st_q <= ST_OFF;
		dis_cnt_q <= 4'h0;
	end else begin
		case (st_q)
			ST_OFF: begin
				if (wr_ctl && ctl_new[`SMC_CTL_EN]) begin
					st_q <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (enter_srst) begin
					st_q <= ST_SRST;
				end else if (wr_ctl && !ctl_new[`SMC_CTL_EN]) begin
					st_q <= ST_DIS; // [R24]
					dis_cnt_q <= 4'h0;
				end
			end
			ST_DIS: begin
				if (dis_cnt_q == DIS_LIM) begin
					st_q <= ST_OFF; // [R24]
				end else begin
					dis_cnt_q <= dis_cnt_q + 4'h1;
				end
			end
			ST_SRST: begin
				if (det_tick && !below_threshold_in) begin
					st_q <= ST_RUN; // [R9] [R7]
				end
			end
			default: st_q <= ST_OFF;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// configuration registers
always @(posedge aclk) begin
	if (!aresetn || enter_srst) begin
		debug_clock_run_q <= `SMC_CLK_DEBUG_CLOCK_RUN_RST; // [R10]
		clock_divider_q <= `SMC_CLK_DIV_RST;
		clock_source_q <= `SMC_CLK_SRC_RST;
	end else if (wr_clk) begin
		debug_clock_run_q <= wd[`SMC_CLK_DEBUG_CLOCK_RUN];
		clock_divider_q <= wd[`SMC_CLK_DIV_HI:`SMC_CLK_DIV_LO];
		if (SRC_IMPL[wd[`SMC_CLK_SRC_HI:`SMC_CLK_SRC_LO]]) begin
			clock_source_q <= wd[`SMC_CLK_SRC_HI:`SMC_CLK_SRC_LO]; // [R16]
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		monitored_source_select <= 1'b0;
		threshold_level <= 5'h00;
		reset_select_q <= 4'h0;
		consec_count_q <= 2'h0;
		cycle_select_q <= 2'h0;
		irq_enable_q <= 1'b0;
	end else if (enter_srst) begin
		consec_count_q <= 2'h0; // [R12] [R7]
		cycle_select_q <= 2'h0;
		irq_enable_q <= 1'b0;
	end else begin
		if (wr_ctl) begin
			monitored_source_select <= ctl_new[`SMC_CTL_SRCSEL]; // [R21]
			if (thr_ok) begin
				threshold_level <= thr_new;
			end
			reset_select_q <= ctl_new[`SMC_CTL_RE_HI:`SMC_CTL_RE_LO];
			cycle_select_q <= ctl_new[`SMC_CTL_MD_HI:`SMC_CTL_MD_LO];
			consec_count_q <= sc_new;
		end
		if (wr_ie) begin
			irq_enable_q <= wd[`SMC_IE_BIT];
		end
	end
end

// set wins over a clear in the same cycle; supply recovery never clears it
always @(posedge aclk) begin
	if (!aresetn) begin
		low_voltage_flag_q <= 1'b0;
	end else begin
		low_voltage_flag_q <= event_hit || (low_voltage_flag_q && !flag_clr); // [R1] [R3] [R11]
	end
end

////////////////////////////////////////////////////////////////////////
// outputs
always @(posedge aclk) begin
	if (!aresetn) begin
		low_voltage_irq <= 1'b0;
		system_reset_req <= 1'b0;
		comparator_enable <= 1'b0;
		external_sense_keep <= 1'b0;
	end else begin
		low_voltage_irq <= low_voltage_flag_q && irq_enable_q && !reset_mode; // [R4] [R1]
		system_reset_req <= enter_srst || (st_q == ST_SRST && !(det_tick && !below_threshold_in)); // [R6] [R9]
		comparator_enable <= (st_q == ST_RUN) || (st_q == ST_SRST);
		external_sense_keep <= monitored_source_select &&
			(enter_srst || (st_q == ST_SRST && !(det_tick && !below_threshold_in))); // [R8]
	end
end

endmodule

// >>> testbench/smc_checker.sv
module smc_checker (
	input logic aclk, // clock
	input logic aresetn, // reset, active low
	input logic s_axi_awvalid, // aw valid
	input logic s_axi_awready, // aw ready
	input logic s_axi_wvalid, // w valid
	input logic s_axi_wready, // w ready
	input logic [1:0] s_axi_bresp, // b resp
	input logic s_axi_bvalid, // b valid
	input logic s_axi_bready, // b ready
	input logic s_axi_arvalid, // ar valid
	input logic s_axi_arready, // ar ready
	input logic [31:0] s_axi_rdata, // r data
	input logic [1:0] s_axi_rresp, // r resp
	input logic s_axi_rvalid, // r valid
	input logic below_threshold_in, // comparator
	input logic low_voltage_irq, // irq
	input logic system_reset_req, // reset request
	input logic comparator_enable, // comparator on
	input logic [4:0] threshold_level, // threshold
	input logic monitored_source_select, // source select
	input logic external_sense_keep // pin keep
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write response");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rdata_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data");
	a_rdata_clean: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && (s_axi_rresp == 2'h0 || s_axi_rdata == 32'h0))
		else $error("read data upper bits set");
	a_irq_excl_reset: assert property (low_voltage_irq |-> !system_reset_req)
		else $error("irq during detector reset");
	// a write can clear flag or enable, so only quiet stretches are held
	a_irq_sticky: assert property (low_voltage_irq && !s_axi_wvalid && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
		|=> low_voltage_irq)
		else $error("irq dropped without a write");
	a_thr_legal: assert property ($changed(threshold_level) |-> threshold_level >= 5'h01 && threshold_level <= 5'h1e)
		else $error("forbidden threshold taken");
	a_keep_pin: assert property (external_sense_keep |-> monitored_source_select
		&& (system_reset_req || $past(system_reset_req)))
		else $error("sense pin kept outside reset");
	a_reset_monitors: assert property (system_reset_req |-> comparator_enable)
		else $error("detector off during reset");
	a_reset_cause: assert property ($rose(system_reset_req) |-> $past(below_threshold_in) || $past(below_threshold_in, 2))
		else $error("reset without low detection");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind smc_supply_monitor smc_checker smc_checker_inst (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .below_threshold_in(below_threshold_in),
	.low_voltage_irq(low_voltage_irq), .system_reset_req(system_reset_req), .comparator_enable(comparator_enable),
	.threshold_level(threshold_level), .monitored_source_select(monitored_source_select),
	.external_sense_keep(external_sense_keep));

// >>> testbench/smc_supply_monitor_tb_top.sv
`include "smc_defs.vh"
module smc_supply_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} smc_row_t;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rd;
	logic [3:0] wstrb = 0, src_tick = 0;
	logic debug_mode = 0, below = 0;
	logic [1:0] rs;
	wire awready, wready, bvalid, arready, rvalid, irq, rst_req, src_sel, keep, cmp_en;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [4:0] thr;
	int error_cnt = 0, samples_checked = 0, irq_cnt, rst_cnt, n;
	// unbuilt source, forbidden threshold, gated count and reserved bits in one pass
	smc_row_t rows [7] = '{'{8'h00, 32'hffff, 32'h0170, 2'h0}, '{8'h04, 32'hfffe, 32'he0f6, 2'h0},
		'{8'h04, 32'h1e00, 32'h7e00, 2'h0}, '{8'h04, 32'h0000, 32'h7e00, 2'h0},
		'{8'h0c, 32'hffff, 32'h0001, 2'h0}, '{8'h08, 32'hfffe, 32'h0000, 2'h0},
		'{8'h10, 32'hffff, 32'h0000, 2'h2}};

	always #4 aclk = ~aclk;
	always @(posedge aclk) src_tick <= 4'hf;

	// external clock input left unbuilt so its selection must be refused
	smc_supply_monitor #(.SRC_IMPL(4'h7)) smc_supply_monitor_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.src_tick(src_tick), .debug_mode(debug_mode), .below_threshold_in(below),
		.low_voltage_irq(irq), .system_reset_req(rst_req), .comparator_enable(cmp_en),
		.threshold_level(thr), .monitored_source_select(src_sel), .external_sense_keep(keep));
	smc_sys_model smc_sys_model_inst (.aclk(aclk), .aresetn(aresetn), .low_voltage_irq(irq),
		.system_reset_req(rst_req), .irq_cnt(irq_cnt), .rst_cnt(rst_cnt));
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'h3;
		awvalid <= 1;
		wvalid <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			ad = ad | awready;
			wd = wd | wready;
			awvalid <= !ad;
			wvalid <= !wd;
		end
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask

	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		rready <= 1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask

	// bounded wait for irq (sel 0) or reset request (sel 1) to reach val
	task automatic wt(input logic sel, input logic val, input int lim);
		n = 0;
		while ((sel ? rst_req : irq) !== val && n < lim) begin
			@(posedge aclk);
			n++;
		end
	endtask

	task results;
		$display("errors %0d, checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		#160000;
		error_cnt++;
		results();
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			rdr(8'(i * 4));
			chk(rd, i == 0 ? 32'h0100 : 32'h0);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk({30'h0, rs}, {30'h0, rows[i].r});
			rdr(rows[i].a);
			chk(rd, rows[i].e);
			chk({30'h0, rs}, {30'h0, rows[i].r});
		end
		wr(`SMC_ADDR_CLK, 32'h0001); // protection is unlocked outside this block
		wr(`SMC_ADDR_FLAG, 32'h0001);
		wr(`SMC_ADDR_IE, 32'h0001);
		wr(`SMC_ADDR_CTL, 32'h1001);
		below <= 1;
		wt(0, 1, 50);
		chk({30'h0, irq, rst_req}, 32'h2);
		rdr(`SMC_ADDR_FLAG);
		chk(rd, 32'h0101);
		below <= 0;
		repeat (20) @(posedge aclk);
		rdr(`SMC_ADDR_FLAG);
		chk(rd, 32'h0001);
		wr(`SMC_ADDR_IE, 32'h0000);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(`SMC_ADDR_IE, 32'h0001);
		wt(0, 1, 5);
		chk({31'h0, irq}, 32'h1);
		wr(`SMC_ADDR_FLAG, 32'h0001);
		wt(0, 0, 5);
		chk({31'h0, irq}, 32'h0);
		below <= 1;
		wt(0, 1, 50);
		below <= 0;
		wr(`SMC_ADDR_CTL, 32'h1000);
		n = 0;
		do begin
			rdr(`SMC_ADDR_CTL);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		chk(rd, 32'h7000);
		chk({31'h0, cmp_en}, 32'h0);
		rdr(`SMC_ADDR_FLAG);
		chk(rd, 32'h0001);
		// rc divided by 4, two lows 128 ticks apart: far slower than continuous
		wr(`SMC_ADDR_CLK, 32'h0000);
		wr(`SMC_ADDR_FLAG, 32'h0001);
		wr(`SMC_ADDR_CTL, 32'h3003);
		below <= 1;
		wt(0, 1, 1500);
		chk({31'h0, n > 400 && n < 1100}, 32'h1);
		below <= 0;
		wr(`SMC_ADDR_FLAG, 32'h0001);
		wr(`SMC_ADDR_CLK, 32'h0061);
		wr(`SMC_ADDR_CTL, 32'hb0a3);
		below <= 1;
		wt(1, 1, 1500);
		chk({22'h0, cmp_en, rst_req, irq, keep, src_sel, thr}, 32'h370);
		rdr(`SMC_ADDR_CLK);
		chk(rd, 32'h0100);
		rdr(`SMC_ADDR_CTL);
		chk(rd, 32'h90a1);
		rdr(`SMC_ADDR_FLAG);
		chk(rd, 32'h0101);
		rdr(`SMC_ADDR_IE);
		chk(rd, 32'h0);
		below <= 0;
		wt(1, 0, 50);
		chk({31'h0, rst_req}, 32'h0);
		below <= 1;
		wt(1, 1, 40);
		chk({31'h0, rst_req}, 32'h1);
		below <= 0;
		wt(1, 0, 50);
		wr(`SMC_ADDR_CLK, 32'h0001);
		debug_mode <= 1;
		// let the last free-running tick pass before the supply drops
		@(posedge aclk);
		below <= 1;
		repeat (100) @(posedge aclk);
		chk({31'h0, rst_req}, 32'h0);
		debug_mode <= 0;
		wt(1, 1, 40);
		chk({31'h0, rst_req}, 32'h1);
		below <= 0;
		wt(1, 0, 50);
		chk(32'(rst_cnt), 32'h3);
		chk(32'(irq_cnt), 32'h4);
		results();
	end
endmodule

// >>> testbench/smc_sys_model.sv
module smc_sys_model (
	input logic aclk, // clock
	input logic aresetn, // reset, active low
	input logic low_voltage_irq, // interrupt request
	input logic system_reset_req, // system reset request
	output int irq_cnt, // interrupts latched
	output int rst_cnt // resets issued
);
	timeunit 1ns;
	timeprecision 1ps;
	logic irq_q, rst_q;
	// level requests latched on their rising edge, as the controllers do
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
			rst_q <= 1'b0;
			irq_cnt <= 0;
			rst_cnt <= 0;
		end else begin
			irq_q <= low_voltage_irq;
			rst_q <= system_reset_req;
			if (low_voltage_irq && !irq_q) irq_cnt <= irq_cnt + 1;
			if (system_reset_req && !rst_q) rst_cnt <= rst_cnt + 1;
		end
	end
endmodule
